// ### src/position_port_pkg.sv
// Constants shared by the position output port and its count helper.
package position_port_pkg;
  localparam int unsigned clk_mhz = 125;
  localparam int unsigned pos_width = 16;
  localparam logic [pos_width-1:0] pos_reset = 16'h0000;
  localparam logic [1:0] res_10 = 2'h0;
  localparam logic [1:0] res_12 = 2'h1;
  localparam logic [1:0] res_14 = 2'h2;
  localparam logic [1:0] res_16 = 2'h3;
  localparam logic [pos_width-1:0] mask_10 = 16'h03FF;
  localparam logic [pos_width-1:0] mask_12 = 16'h0FFF;
  localparam logic [pos_width-1:0] mask_14 = 16'h3FFF;
  localparam logic [pos_width-1:0] mask_16 = 16'hFFFF;
  localparam int unsigned shift_10 = 6;
  localparam int unsigned shift_12 = 4;
  localparam int unsigned shift_14 = 2;
  localparam int unsigned shift_16 = 0;
  localparam int unsigned byte_width = 8;
  localparam logic [31:0] addr_ctrl = 32'h0000_0000;
  localparam logic [31:0] addr_status = 32'h0000_0004;
  localparam logic [31:0] addr_mask = 32'h0000_0008;
  localparam logic [31:0] addr_position = 32'h0000_000C;
  localparam logic [31:0] addr_latched = 32'h0000_0010;
  localparam int unsigned ev_wrap = 0;
  localparam int unsigned ev_reverse = 1;
  localparam int unsigned ev_load = 2;
  localparam int unsigned ev_count = 3;
  localparam logic [3:0] mask_reset = 4'h0;
endpackage

// ### src/position_counter.sv
// Position counter stepping by one unit at the selected resolution.
`timescale 1ns/1ps
`default_nettype none
module position_counter
  import position_port_pkg::*;
#(
  parameter int unsigned width = pos_width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic step_up,
  input wire logic load,
  input wire logic [width-1:0] load_value,
  input wire logic [1:0] resolution_select,
  output logic [width-1:0] count,
  output logic wrapped
);
  import position_port_pkg::*;

  typedef struct packed {
    logic [width-1:0] count;
    logic wrapped;
  } counter_state_t;

  counter_state_t state;
  counter_state_t next_state;
  logic [width-1:0] mask;

  always_comb begin
    case (resolution_select)
      res_10: mask = mask_10;
      res_12: mask = mask_12;
      res_14: mask = mask_14;
      default: mask = mask_16;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.wrapped = 1'b0;
    if (load) begin
      next_state.count = load_value & mask;
    end else if (step) begin
      if (step_up) begin
        next_state.count = (state.count + 1'b1) & mask;
        next_state.wrapped = ((state.count & mask) == mask);
      end else begin
        next_state.count = (state.count - 1'b1) & mask;
        next_state.wrapped = ((state.count & mask) == '0);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{count: pos_reset, wrapped: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;
  assign wrapped = state.wrapped;
endmodule
`default_nettype wire

// ### src/tracking_position_output_port.sv
// Position output port of a tracking converter with an APB register file.
// Operation
// - Output enable high floats the data pins; low drives the latched word.
// - Half-select high puts the high byte on the low pins, else low byte.
// - Latch hold low freezes the output latch; high resumes copying.
// - Pin-direction low makes data pins inputs loading the count.
// - Busy is high while the count updates; data then invalid.
// - A direction output shows whether the angle rises or falls.
// - A wrap pulse marks roll-over between all ones and all zeros.
// - Two resolution-select inputs choose 10, 12, 14 or 16 bits.
// - The count is unsigned natural binary over one revolution.
// - Every single-unit step of the count gives one busy pulse.
// - Direction is latched, changes on reversal, valid before wrap.
// - Wrap and direction keep working while the latch is held.
`timescale 1ns/1ps
`default_nettype none
module tracking_position_output_port
  import position_port_pkg::*;
#(
  parameter int unsigned width = pos_width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step,
  input wire logic step_up,
  input wire logic output_enable_n,
  input wire logic byte_select,
  input wire logic latch_hold_n,
  input wire logic data_load_n,
  input wire logic [1:0] resolution_select,
  input wire logic [width-1:0] position_bus_in,
  output logic [width-1:0] position_bus_out,
  output logic [width-1:0] position_bus_oe,
  output logic busy,
  output logic direction,
  output logic wrap_pulse,
  output logic irq
);
  import position_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record.

  typedef struct packed {
    logic [width-1:0] latched;
    logic [width-1:0] bus_out;
    logic [width-1:0] bus_oe;
    logic busy;
    logic direction;
    logic wrap;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic soft_hold;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;
  logic [width-1:0] count;
  logic wrapped;
  logic load;
  logic [width-1:0] aligned;
  logic [width-1:0] word;
  logic [3:0] events;
  logic access;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and pin handling.

  assign load = !data_load_n;

  position_counter #(
    .width(width)
  ) counter_i (
    .pclk(pclk),
    .presetn(presetn),
    .step(step && data_load_n),
    .step_up(step_up),
    .load(load),
    .load_value(position_bus_in),
    .resolution_select(resolution_select),
    .count(count),
    .wrapped(wrapped)
  );

  always_comb begin
    case (resolution_select)
      res_10: aligned = width'(count << shift_10);
      res_12: aligned = width'(count << shift_12);
      res_14: aligned = width'(count << shift_14);
      default: aligned = width'(count << shift_16);
    endcase
  end

  assign access = psel && penable && !state.ready;
  assign rd_status = access && !pwrite && (paddr == addr_status);
  assign events = {step && data_load_n, load,
                   step && data_load_n && (step_up != state.direction),
                   state.wrap};

  always_comb begin
    next_state = state;
    next_state.busy = step && data_load_n;
    if (step && data_load_n) begin
      next_state.direction = step_up;
    end
    next_state.wrap = wrapped;
    if (latch_hold_n && !state.soft_hold && !state.busy) begin
      next_state.latched = aligned;
    end
    word = state.latched;
    if (byte_select) begin
      word = {state.latched[width-1:byte_width],
              state.latched[width-1:byte_width]};
    end
    next_state.bus_out = word;
    next_state.bus_oe = (!output_enable_n && data_load_n) ? '1 : '0;
    next_state.ready = access;
    next_state.slverr = 1'b0;
    next_state.rdata = 32'h0000_0000;
    next_state.status = (rd_status ? 4'h0 : state.status) | events;
    if (access) begin
      if (pwrite) begin
        case (paddr)
          addr_ctrl: next_state.soft_hold = pwdata[0];
          addr_mask: next_state.mask = pwdata[3:0];
          addr_status, addr_position, addr_latched: ;
          default: next_state.slverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          addr_ctrl: next_state.rdata = {31'h0, state.soft_hold};
          addr_status: next_state.rdata = {28'h0, state.status};
          addr_mask: next_state.rdata = {28'h0, state.mask};
          addr_position: next_state.rdata = 32'(count);
          addr_latched: next_state.rdata = 32'(state.latched);
          default: next_state.slverr = 1'b1;
        endcase
      end
    end
    next_state.irq = |(next_state.status & state.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{latched: pos_reset, bus_out: pos_reset, bus_oe: '0,
                 busy: 1'b0, direction: 1'b1, wrap: 1'b0, status: 4'h0,
                 mask: mask_reset, rdata: 32'h0000_0000, ready: 1'b0,
                 slverr: 1'b0, irq: 1'b0, soft_hold: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign position_bus_out = state.bus_out;
  assign position_bus_oe = state.bus_oe;
  assign busy = state.busy;
  assign direction = state.direction;
  assign wrap_pulse = state.wrap;
  assign irq = state.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence step_taken_s;
    step && data_load_n;
  endsequence

  sequence busy_seen_s;
    ##1 busy;
  endsequence

  busy_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_taken_s |-> busy_seen_s) else $error("busy missing after step");
  busy_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> $past(step && data_load_n))
    else $error("busy without step");
  float_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    output_enable_n |=> position_bus_oe == '0)
    else $error("pins driven while disabled");
  load_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    !data_load_n |=> position_bus_oe == '0)
    else $error("pins driven while loading");
  drive_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!output_enable_n && data_load_n) |=> position_bus_oe == '1)
    else $error("pins not driven");
  high_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_select |=> position_bus_out[byte_width-1:0] ==
      $past(state.latched[width-1:byte_width]))
    else $error("wrong byte on low pins");
  hold_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_hold_n |=> $stable(state.latched))
    else $error("latch moved while held");
  dir_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_taken_s |=> direction == $past(step_up))
    else $error("direction not updated");
  wrap_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_pulse |-> $past(busy)) else $error("wrap without step");
  soft_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    state.soft_hold |=> $stable(state.latched))
    else $error("latch moved while soft held");
  dir_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(step && data_load_n) |=> $stable(direction))
    else $error("direction moved without step");
endmodule
`default_nettype wire

// ### dv/host_model.sv
// Host side model that resolves the shared position pins.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire logic drive,
  input wire logic [15:0] value,
  input wire logic [15:0] dev_out,
  input wire logic [15:0] dev_oe,
  output logic [15:0] pins
);
  logic [15:0] last;
  initial last = 16'h0000;
  always @(posedge pclk) begin
    last <= pins;
  end
  // Pins that nobody drives show the inverse of their last level.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pins[i] = dev_oe[i] ? dev_out[i] : (drive ? value[i] : ~last[i]);
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the tracking position output port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import position_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic step = 1'b0, step_up = 1'b1, oen = 1'b1, bsel = 1'b0;
  logic hold_n = 1'b1, load_n = 1'b1, drive = 1'b0;
  logic busy, dir, wrap, irq;
  logic [1:0] res = res_16;
  logic [15:0] dval = 16'h0, pin_in, pout, poe;
  logic [15:0] m [4] = '{mask_10, mask_12, mask_14, mask_16};
  int s [4] = '{shift_10, shift_12, shift_14, shift_16};
  int failures = 0, num_checks = 0, cycles = 0;
  initial begin
    forever #4 pclk = ~pclk;
  end
  tracking_position_output_port dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step(step), .step_up(step_up), .output_enable_n(oen),
    .byte_select(bsel), .latch_hold_n(hold_n), .data_load_n(load_n),
    .resolution_select(res), .position_bus_in(pin_in),
    .position_bus_out(pout), .position_bus_oe(poe), .busy(busy),
    .direction(dir), .wrap_pulse(wrap), .irq(irq));
  host_model host (.pclk(pclk), .drive(drive), .value(dval),
    .dev_out(pout), .dev_oe(poe), .pins(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stp(input logic up, input logic w);
    step <= 1'b1;
    step_up <= up;
    @(posedge pclk);
    step <= 1'b0;
    #1;
    check(busy, 1'b1);
    check(dir, up);
    @(posedge pclk);
    #1;
    check(wrap, w);
    check(busy, 1'b0);
    repeat (2) @(posedge pclk);
  endtask
  task automatic load(input logic [15:0] v);
    drive <= 1'b1;
    dval <= v;
    load_n <= 1'b0;
    repeat (2) @(posedge pclk);
    load_n <= 1'b1;
    drive <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    load(16'hFFFE);
    apb(1'b0, addr_position);
    check(rd, 32'h0000FFFE);
    stp(1'b1, 1'b0);
    stp(1'b1, 1'b1);
    apb(1'b0, addr_position);
    check(rd, 32'h0);
    apb(1'b0, addr_status);
    check(rd, 32'hD);
    load(16'h12A5);
    #1;
    check(poe, 16'h0);
    @(posedge pclk);
    oen <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check(poe, 16'hFFFF);
    check(pout[7:0], 8'hA5);
    @(posedge pclk);
    bsel <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check(pout[7:0], 8'h12);
    @(posedge pclk);
    oen <= 1'b1;
    bsel <= 1'b0;
    hold_n <= 1'b0;
    load(16'h0000);
    stp(1'b0, 1'b1);
    apb(1'b0, addr_latched);
    check(rd, 32'h000012A5);
    apb(1'b0, addr_status);
    check(rd, 32'hF);
    hold_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, addr_latched);
    check(rd, 32'h0000FFFF);
    for (int i = 0; i < 4; i++) begin
      res <= i[1:0];
      load(16'h0000);
      stp(1'b0, 1'b1);
      apb(1'b0, addr_position);
      check(rd, {16'h0, m[i]});
      apb(1'b0, addr_latched);
      check(rd, {16'h0, m[i] << s[i]});
    end
    apb(1'b0, addr_status);
    pwdata <= 32'h1;
    apb(1'b1, addr_mask);
    stp(1'b1, 1'b1);
    #1;
    check(irq, 1'b1);
    @(posedge pclk);
    apb(1'b0, addr_status);
    check(rd[0], 1'b1);
    #1;
    check(irq, 1'b0);
    @(posedge pclk);
    stp(1'b1, 1'b0);
    #1;
    check(irq, 1'b0);
    @(posedge pclk);
    apb(1'b0, 32'h0000_0020);
    check(err, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
